//--- rtl/alarm_latch_pkg.sv
// constants for the modem alarm latch and loop mode block.
// assumes a single 40 MHz system clock and a 32-bit Avalon-MM register bus.
package alarm_latch_pkg;

   // clock and timing
   localparam longint unsigned CLK_HZ = 64'd40_000_000;
   localparam longint unsigned MODE_CLEAR_S = 64'd53;
   // a longest interval, so the cycle count rounds down (exact here)
   localparam longint unsigned MODE_CLEAR_CYCLES = (MODE_CLEAR_S * CLK_HZ);
   localparam int TIMER_W = 32;

   // register byte offsets
   localparam logic [4:0] STATUS_OFS = 5'h00;
   localparam logic [4:0] CMD_OFS = 5'h04;
   localparam logic [4:0] IRQ_STATUS_OFS = 5'h08;
   localparam logic [4:0] IRQ_CLEAR_OFS = 5'h0c;
   localparam logic [4:0] IRQ_ENABLE_OFS = 5'h10;
   localparam logic [4:0] TIMER_OFS = 5'h14;

   // status register fields
   localparam int ST_LOCK_WARN = 0;
   localparam int ST_OPEN_WARN = 1;
   localparam int ST_SWITCH_WARN = 2;
   localparam int ST_BYPASS = 3;
   localparam int ST_TX_PHASE = 4;

   // command register fields (each bit is a one-shot command)
   localparam int CMD_ALARM_CLEAR = 0;
   localparam int CMD_BYPASS = 1;
   localparam int CMD_ACQUIRE = 2;

   // interrupt event fields
   localparam int IRQ_W = 4;
   localparam int EV_LOCK_WARN = 0;
   localparam int EV_OPEN_WARN = 1;
   localparam int EV_SWITCH_WARN = 2;
   localparam int EV_TIMER_CLEAR = 3;
   localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 4'h0;

   // synchronised pin vector layout
   localparam int PIN_W = 9;
   localparam int PIN_LOCK = 0;
   localparam int PIN_OPEN = 1;
   localparam int PIN_SW_A = 2;
   localparam int PIN_SW_B = 3;
   localparam int PIN_PHASE = 4;
   localparam int PIN_STROBE = 5;
   localparam int PIN_CLEAR = 6;
   localparam int PIN_BYPASS = 7;
   localparam int PIN_ACQUIRE = 8;

endpackage

//--- rtl/modem_alarm_and_mode_latch.sv
// modem warning latches, loop bypass/acquire mode bit, amplifier supply gating
// and an Avalon-MM register slave with a level interrupt.
// assumes every modem and command pin is asynchronous to mclk; tx_rx_phase high is transmit.
`timescale 1ns/100ps

// Overview of operation
// - each of the three modem warnings is held in its own set-reset flag, and the flag is reported.
// - a short high on the lock or open-loop warning keeps its flag set until a clear command.
// - the switch warning flag sets when either of the two manual switches is moved and stays.
// - a bypass command sets the single mode bit, which puts the modem loop into backup.
// - an acquire command clears the mode bit, low being the normal searching state.
// - power-up forces the mode bit to acquire with no command.
// - a free-running timer clears the mode bit every 53 seconds whatever the commands.
// - latched flags and analog points share the one monitor channel for reporting.
// - the transmit amplifier supply is on in transmit and off in receive.
// - the first receive amplifier supply is off in transmit and on in receive.
// - a clear command acts when the decoded clear and the command strobe coincide, or on a byte-0 bus write to the command register.
// - timer and power-on clears of the mode bit beat a simultaneous bypass command.
module modem_alarm_and_mode_latch
#(
   parameter longint unsigned MODE_CLEAR_CYCLES = alarm_latch_pkg::MODE_CLEAR_CYCLES
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,

   // register bus, Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,

   // modem warnings
   input wire logic pll_lock_alarm,
   input wire logic open_loop_alarm,
   input wire logic switch_a_moved,
   input wire logic switch_b_moved,

   // communications system commands
   input wire logic cmd_strobe,
   input wire logic alarm_clear_cmd,
   input wire logic loop_bypass_cmd,
   input wire logic loop_acquire_cmd,

   // transmit/receive phase
   input wire logic tx_rx_phase,

   // to the monitor multiplexer
   output logic lock_warn_flag,
   output logic open_loop_warn_flag,
   output logic manual_switch_alarm,

   // to the modem loop and the amplifier supplies
   output logic loop_bypass_out,
   output logic tx_amp_enable,
   output logic rx_amp_enable
);

   localparam int TW = alarm_latch_pkg::TIMER_W;
   localparam int PW = alarm_latch_pkg::PIN_W;
   localparam int IW = alarm_latch_pkg::IRQ_W;
   localparam logic [TW-1:0] TIMER_LAST = TW'(MODE_CLEAR_CYCLES - 64'd1);

   typedef struct packed
   {
      logic [PW-1:0] sync1;
      logic [PW-1:0] sync2;
      logic strobe_d;
      logic lock_flag;
      logic open_flag;
      logic switch_flag;
      logic bypass;
      logic tx_en;
      logic rx_en;
      logic [TW-1:0] timer;
      logic [IW-1:0] irq_st;
      logic [IW-1:0] irq_en;
      logic irq;
      logic wait_n;
      logic [31:0] rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   always_comb
   begin
      logic strobe_rise;
      logic clear_req;
      logic bypass_req;
      logic acquire_req;
      logic timer_tick;
      logic bus_req;
      logic bus_accept;
      logic bus_wr;
      logic [IW-1:0] events;
      logic [IW-1:0] irq_clear;
      logic [31:0] rd;
      strobe_rise = 1'b0;
      clear_req = 1'b0;
      bypass_req = 1'b0;
      acquire_req = 1'b0;
      timer_tick = 1'b0;
      bus_req = 1'b0;
      bus_accept = 1'b0;
      bus_wr = 1'b0;
      events = '0;
      irq_clear = '0;
      rd = '0;

      s_nxt = s_r;

      // two-stage synchronisers; only sync2 is looked at by any logic
      s_nxt.sync1[alarm_latch_pkg::PIN_LOCK] = pll_lock_alarm;
      s_nxt.sync1[alarm_latch_pkg::PIN_OPEN] = open_loop_alarm;
      s_nxt.sync1[alarm_latch_pkg::PIN_SW_A] = switch_a_moved;
      s_nxt.sync1[alarm_latch_pkg::PIN_SW_B] = switch_b_moved;
      s_nxt.sync1[alarm_latch_pkg::PIN_PHASE] = tx_rx_phase;
      s_nxt.sync1[alarm_latch_pkg::PIN_STROBE] = cmd_strobe;
      s_nxt.sync1[alarm_latch_pkg::PIN_CLEAR] = alarm_clear_cmd;
      s_nxt.sync1[alarm_latch_pkg::PIN_BYPASS] = loop_bypass_cmd;
      s_nxt.sync1[alarm_latch_pkg::PIN_ACQUIRE] = loop_acquire_cmd;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.strobe_d = s_r.sync2[alarm_latch_pkg::PIN_STROBE];

      // a command counts once, on the rising edge of the strobe
      strobe_rise = s_r.sync2[alarm_latch_pkg::PIN_STROBE] & ~s_r.strobe_d;

      // bus handshake: one wait cycle, then the request is accepted
      bus_req = avs_read | avs_write;
      if (bus_req && s_r.wait_n)
      begin
         bus_accept = 1'b1;
         // a write with the low byte lane off changes nothing
         bus_wr = avs_write & avs_byteenable[0];
      end

      // command sources: strobed pins, or a byte-0 write to the command register
      // a strobe held high counts once, as only its rising edge is taken
      if (strobe_rise)
      begin
         clear_req = s_r.sync2[alarm_latch_pkg::PIN_CLEAR];
         bypass_req = s_r.sync2[alarm_latch_pkg::PIN_BYPASS];
         acquire_req = s_r.sync2[alarm_latch_pkg::PIN_ACQUIRE];
      end
      if (bus_wr && avs_address == alarm_latch_pkg::CMD_OFS)
      begin
         // the bus write is its own strobe
         clear_req = clear_req | avs_writedata[alarm_latch_pkg::CMD_ALARM_CLEAR];
         bypass_req = bypass_req | avs_writedata[alarm_latch_pkg::CMD_BYPASS];
         acquire_req = acquire_req | avs_writedata[alarm_latch_pkg::CMD_ACQUIRE];
      end

      // free-running mode timer on mclk
      // the count wraps at the last value, so the period is exactly MODE_CLEAR_CYCLES
      if (s_r.timer == TIMER_LAST)
      begin
         s_nxt.timer = '0;
         timer_tick = 1'b1;
      end
      else
      begin
         s_nxt.timer = s_r.timer + TW'(1);
      end

      // warning flags: a new warning in the clearing cycle survives the clear
      if (s_r.sync2[alarm_latch_pkg::PIN_LOCK])
      begin
         s_nxt.lock_flag = 1'b1;
      end
      else if (clear_req)
      begin
         s_nxt.lock_flag = 1'b0;
      end

      if (s_r.sync2[alarm_latch_pkg::PIN_OPEN])
      begin
         s_nxt.open_flag = 1'b1;
      end
      else if (clear_req)
      begin
         s_nxt.open_flag = 1'b0;
      end

      if (s_r.sync2[alarm_latch_pkg::PIN_SW_A] || s_r.sync2[alarm_latch_pkg::PIN_SW_B])
      begin
         s_nxt.switch_flag = 1'b1;
      end
      else if (clear_req)
      begin
         s_nxt.switch_flag = 1'b0;
      end

      events[alarm_latch_pkg::EV_LOCK_WARN] = s_nxt.lock_flag & ~s_r.lock_flag;
      events[alarm_latch_pkg::EV_OPEN_WARN] = s_nxt.open_flag & ~s_r.open_flag;
      events[alarm_latch_pkg::EV_SWITCH_WARN] = s_nxt.switch_flag & ~s_r.switch_flag;
      events[alarm_latch_pkg::EV_TIMER_CLEAR] = timer_tick;

      // mode bit: the clears are tested ahead of bypass in the if chain so they win a tie
      if (timer_tick)
      begin
         s_nxt.bypass = 1'b0;
      end
      else if (acquire_req)
      begin
         s_nxt.bypass = 1'b0;
      end
      else if (bypass_req)
      begin
         // holding bypass relies on the far side repeating it inside the timer period
         s_nxt.bypass = 1'b1;
      end

      // amplifier supply gating follows the phase directly
      // both supplies switch on the same edge, so neither side overlaps the other
      if (s_r.sync2[alarm_latch_pkg::PIN_PHASE])
      begin
         s_nxt.tx_en = 1'b1;
         s_nxt.rx_en = 1'b0;
      end
      else
      begin
         s_nxt.tx_en = 1'b0;
         s_nxt.rx_en = 1'b1;
      end

      // register writes
      if (bus_wr)
      begin
         if (avs_address == alarm_latch_pkg::IRQ_CLEAR_OFS)
         begin
            irq_clear = avs_writedata[IW-1:0];
         end
         else if (avs_address == alarm_latch_pkg::IRQ_ENABLE_OFS)
         begin
            s_nxt.irq_en = avs_writedata[IW-1:0];
         end
      end

      // sticky status: an event in the clearing cycle wins
      s_nxt.irq_st = (s_r.irq_st & ~irq_clear) | events;
      s_nxt.irq = |(s_r.irq_st & s_r.irq_en);

      // read data is prepared in the wait cycle and stands at the accept edge
      if (avs_address == alarm_latch_pkg::STATUS_OFS)
      begin
         rd[alarm_latch_pkg::ST_LOCK_WARN] = s_r.lock_flag;
         rd[alarm_latch_pkg::ST_OPEN_WARN] = s_r.open_flag;
         rd[alarm_latch_pkg::ST_SWITCH_WARN] = s_r.switch_flag;
         rd[alarm_latch_pkg::ST_BYPASS] = s_r.bypass;
         rd[alarm_latch_pkg::ST_TX_PHASE] = s_r.tx_en;
      end
      else if (avs_address == alarm_latch_pkg::IRQ_STATUS_OFS)
      begin
         rd[IW-1:0] = s_r.irq_st;
      end
      else if (avs_address == alarm_latch_pkg::IRQ_ENABLE_OFS)
      begin
         rd[IW-1:0] = s_r.irq_en;
      end
      else if (avs_address == alarm_latch_pkg::TIMER_OFS)
      begin
         rd[TW-1:0] = s_r.timer;
      end
      else if (avs_address == alarm_latch_pkg::CMD_OFS)
      begin
         // write-only: one-shot commands leave nothing to read back
         rd = '0;
      end
      else if (avs_address == alarm_latch_pkg::IRQ_CLEAR_OFS)
      begin
         rd = '0;
      end
      else
      begin
         // holes read as zero so software can probe safely
         rd = '0;
      end

      if (bus_req && !s_r.wait_n)
      begin
         s_nxt.rdata = avs_read ? rd : 32'h0000_0000;
         s_nxt.wait_n = 1'b1;
      end
      else if (bus_accept)
      begin
         s_nxt.wait_n = 1'b0;
      end
      else
      begin
         // a request withdrawn before its accept must not leave waitrequest low
         s_nxt.wait_n = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_r.sync1 <= '0;
         s_r.sync2 <= '0;
         s_r.strobe_d <= 1'b0;
         s_r.lock_flag <= 1'b0;
         s_r.open_flag <= 1'b0;
         s_r.switch_flag <= 1'b0;
         s_r.bypass <= 1'b0;
         s_r.tx_en <= 1'b0;
         s_r.rx_en <= 1'b1;
         s_r.timer <= '0;
         s_r.irq_st <= '0;
         s_r.irq_en <= alarm_latch_pkg::IRQ_ENABLE_RST;
         s_r.irq <= 1'b0;
         s_r.wait_n <= 1'b0;
         s_r.rdata <= 32'h0000_0000;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // every output is driven from the registered state, avs_waitrequest as the inverse of wait_n
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = ~s_r.wait_n;
   assign irq = s_r.irq;
   // the flags go to the shared monitor multiplexer beside the analog points
   assign lock_warn_flag = s_r.lock_flag;
   assign open_loop_warn_flag = s_r.open_flag;
   assign manual_switch_alarm = s_r.switch_flag;
   assign loop_bypass_out = s_r.bypass;
   assign tx_amp_enable = s_r.tx_en;
   assign rx_amp_enable = s_r.rx_en;

endmodule // modem_alarm_and_mode_latch

//--- tb/mode_latch_asserts.sv
// checker for the alarm latch: flags, mode bit, supply gates, bus handshake
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
module mode_latch_asserts
#(
   parameter longint unsigned MODE_CLEAR_CYCLES = 200
)
(
   // clock, reset, bus
   input wire logic mclk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // modem and command pins
   input wire logic pll_lock_alarm,
   input wire logic switch_a_moved,
   input wire logic switch_b_moved,
   input wire logic cmd_strobe,
   input wire logic alarm_clear_cmd,
   input wire logic loop_acquire_cmd,
   input wire logic tx_rx_phase,
   // outputs
   input wire logic lock_warn_flag,
   input wire logic open_loop_warn_flag,
   input wire logic manual_switch_alarm,
   input wire logic loop_bypass_out,
   input wire logic tx_amp_enable,
   input wire logic rx_amp_enable
);
   logic [2:0] quiet_r;
   longint unsigned high_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // a clear needs a strobe or bus write, so no flag may fall this long after one
   always_ff @(posedge mclk)
   begin
      if (reset || cmd_strobe || avs_write)
         quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
         quiet_r <= quiet_r + 3'h1;
      high_r <= (reset || !loop_bypass_out) ? 0 : high_r + 1;
   end
   property p_lock_set;
      pll_lock_alarm |-> ##[3:4] lock_warn_flag;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock flag not set");
   property p_sw_set;
      switch_a_moved || switch_b_moved |-> ##[1:4] manual_switch_alarm;
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("switch flag not set");
   property p_sticky;
      quiet_r == 3'h7 |-> !$fell(lock_warn_flag) && !$fell(open_loop_warn_flag)
         && !$fell(manual_switch_alarm);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag fell unasked");
   property p_clear;
      !pll_lock_alarm [*4] ##0 ($rose(cmd_strobe) && alarm_clear_cmd)
         ##1 !pll_lock_alarm [*4] |=> !lock_warn_flag;
   endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
   property p_acquire;
      $rose(cmd_strobe) && loop_acquire_cmd |-> ##5 !loop_bypass_out;
   endproperty
   a_acquire: assert property (p_acquire) else $error("acquire ignored");
   property p_timer;
      high_r < MODE_CLEAR_CYCLES;
   endproperty
   a_timer: assert property (p_timer) else $error("bypass outlived timer");
   property p_por;
      $fell(reset) |-> !loop_bypass_out && !lock_warn_flag && !manual_switch_alarm;
   endproperty
   a_por: assert property (p_por) else $error("not clear after reset");
   property p_tx;
      tx_rx_phase [*4] |=> ##2 (tx_amp_enable && !rx_amp_enable);
   endproperty
   a_tx: assert property (p_tx) else $error("supplies wrong in transmit");
   property p_rx;
      !tx_rx_phase [*4] |=> ##2 (!tx_amp_enable && rx_amp_enable);
   endproperty
   a_rx: assert property (p_rx) else $error("supplies wrong in receive");
   property p_wait;
      $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer timing");
endmodule // mode_latch_asserts
bind modem_alarm_and_mode_latch mode_latch_asserts
   #(.MODE_CLEAR_CYCLES(MODE_CLEAR_CYCLES)) u_chk (.*);

//--- tb/cmd_link_model.sv
// command side model: decoded command levels qualified by a strobe
// assumes send is entered just after a rising edge of mclk
`timescale 1ns/100ps
module cmd_link_model
(
   // clock
   input wire logic mclk,
   // command lines
   output logic cmd_strobe,
   output logic alarm_clear_cmd,
   output logic loop_bypass_cmd,
   output logic loop_acquire_cmd
);
   initial
   begin
      cmd_strobe = 1'b0;
      {alarm_clear_cmd, loop_bypass_cmd, loop_acquire_cmd} = 3'h0;
   end
   // c is {clear, bypass, acquire}; hold sets how slowly the strobe drops
   task automatic send(input logic [2:0] c, input int hold);
      {alarm_clear_cmd, loop_bypass_cmd, loop_acquire_cmd} <= c;
      @(posedge mclk);
      cmd_strobe <= 1'b1;
      repeat (hold) @(posedge mclk);
      cmd_strobe <= 1'b0;
      @(posedge mclk);
      // released lines are not held: show the inverse, never a stale level
      {alarm_clear_cmd, loop_bypass_cmd, loop_acquire_cmd} <= ~c;
   endtask
endmodule // cmd_link_model

//--- tb/modem_alarm_and_mode_latch_tb.sv
// self-checking bench for the modem alarm and mode latch
// assumes the command link model and the bound checker
`timescale 1ns/100ps
module modem_alarm_and_mode_latch_tb;
   logic mclk, reset, avs_read, avs_write, tx_rx_phase;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable, warn;
   logic avs_waitrequest, irq, cmd_strobe, alarm_clear_cmd, loop_bypass_cmd, loop_acquire_cmd;
   logic lock_warn_flag, open_loop_warn_flag, manual_switch_alarm;
   logic loop_bypass_out, tx_amp_enable, rx_amp_enable;
   wire pll_lock_alarm = warn[0];
   wire open_loop_alarm = warn[1];
   wire switch_a_moved = warn[2];
   wire switch_b_moved = warn[3];
   wire [2:0] flags = {manual_switch_alarm, open_loop_warn_flag, lock_warn_flag};
   int mismatches, tests_run;
   modem_alarm_and_mode_latch #(.MODE_CLEAR_CYCLES(200)) dut (.*);
   cmd_link_model link (.mclk(mclk), .cmd_strobe(cmd_strobe), .alarm_clear_cmd(alarm_clear_cmd),
      .loop_bypass_cmd(loop_bypass_cmd), .loop_acquire_cmd(loop_acquire_cmd));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one bus transfer; the request stands until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0 && ++n < 50);
      chk("bus_answer", n < 50, 1'b1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // one idle edge, so a following call never re-raises a request in this step
      @(posedge mclk);
   endtask
   task automatic t_por;
      chk("flags", flags, 3'h0);
      chk("bypass", loop_bypass_out, 1'b0);
      chk("rx_en", rx_amp_enable, 1'b1);
      bus(1'b0, 5'h00, 32'h0, rd);
      chk("status", rd, 32'h0);
      bus(1'b0, 5'h1c, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      $display("t_por done");
   endtask
   task automatic t_regs;
      avs_byteenable <= 4'he;
      bus(1'b1, 5'h10, 32'hf, rd);
      avs_byteenable <= 4'hf;
      bus(1'b0, 5'h10, 32'h0, rd);
      chk("be_off", rd, 32'h0);
      bus(1'b1, 5'h04, 32'h2, rd);
      chk("reg_byp", loop_bypass_out, 1'b1);
      bus(1'b0, 5'h00, 32'h0, rd);
      chk("st_byp", rd[3], 1'b1);
      bus(1'b1, 5'h04, 32'h6, rd);
      chk("acq_wins", loop_bypass_out, 1'b0);
      warn[0] <= 1'b1;
      @(posedge mclk);
      warn[0] <= 1'b0;
      repeat (5) @(posedge mclk);
      chk("lock_set", lock_warn_flag, 1'b1);
      bus(1'b1, 5'h04, 32'h1, rd);
      chk("reg_clr", lock_warn_flag, 1'b0);
      bus(1'b0, 5'h14, 32'h0, rd);
      chk("timer", rd < 200, 1'b1);
      $display("t_regs done");
   endtask
   task automatic t_phase;
      tx_rx_phase <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("tx_en", tx_amp_enable, 1'b1);
      chk("rx_off", rx_amp_enable, 1'b0);
      bus(1'b0, 5'h00, 32'h0, rd);
      chk("st_tx", rd[4], 1'b1);
      tx_rx_phase <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("tx_off", tx_amp_enable, 1'b0);
      chk("rx_on", rx_amp_enable, 1'b1);
      $display("t_phase done");
   endtask
   task automatic t_warn;
      int ev;
      for (int i = 0; i < 4; i++)
      begin
         ev = (i == 3) ? 2 : i;
         bus(1'b1, 5'h0c, 32'hf, rd);
         bus(1'b1, 5'h10, 32'h1 << ev, rd);
         warn[i] <= 1'b1;
         @(posedge mclk);
         warn[i] <= 1'b0;
         repeat (8) @(posedge mclk);
         chk("flag", flags[ev], 1'b1);
         chk("irq", irq, 1'b1);
         bus(1'b0, 5'h00, 32'h0, rd);
         chk("st_flag", rd[ev], 1'b1);
         bus(1'b1, 5'h10, 32'h0, rd);
         repeat (2) @(posedge mclk);
         chk("irq_mask", irq, 1'b0);
         link.send(3'h4, i + 1);
         repeat (6) @(posedge mclk);
         chk("cleared", flags[ev], 1'b0);
         bus(1'b1, 5'h0c, 32'hf, rd);
         bus(1'b0, 5'h08, 32'h0, rd);
         chk("irq_st", rd[2:0], 3'h0);
      end
      $display("t_warn done");
   endtask
   // waits for the mode timer event, then acknowledges it
   task automatic tick;
      int n;
      n = 0;
      bus(1'b1, 5'h0c, 32'hf, rd);
      repeat (2) @(posedge mclk);
      while (irq !== 1'b1 && n < 300)
      begin
         @(posedge mclk);
         n++;
      end
      chk("tick", irq, 1'b1);
      bus(1'b1, 5'h0c, 32'h8, rd);
   endtask
   task automatic t_mode;
      bus(1'b1, 5'h10, 32'h8, rd);
      tick;
      link.send(3'h2, 1);
      repeat (6) @(posedge mclk);
      chk("bypass", loop_bypass_out, 1'b1);
      link.send(3'h1, 3);
      repeat (6) @(posedge mclk);
      chk("acquire", loop_bypass_out, 1'b0);
      link.send(3'h2, 2);
      repeat (6) @(posedge mclk);
      chk("bypass_again", loop_bypass_out, 1'b1);
      tick;
      chk("timer_clr", loop_bypass_out, 1'b0);
      link.send(3'h2, 1);
      repeat (6) @(posedge mclk);
      chk("resend", loop_bypass_out, 1'b1);
      bus(1'b1, 5'h04, 32'h4, rd);
      repeat (5) @(posedge mclk);
      chk("reg_acq", loop_bypass_out, 1'b0);
      $display("t_mode done");
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      #(25 * 8000);
      mismatches++;
      finish_test();
   end
   initial
   begin
      reset = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      warn = 4'h0;
      tx_rx_phase = 1'b0;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_por();
      t_regs();
      t_phase();
      t_warn();
      t_mode();
      finish_test();
   end
endmodule // modem_alarm_and_mode_latch_tb
